// File: src/rfa_pkg.sv
// Package with register addresses, field positions and command codes of the register file addresser.
package rfa_pkg;
  localparam logic [7:0] RFA_ADDR_SLICE_ZERO  = 8'hD6;
  localparam logic [7:0] RFA_ADDR_SLICE_ONE   = 8'hD7;
  localparam logic [7:0] RFA_ADDR_STACK_HIGH  = 8'hD8;
  localparam logic [7:0] RFA_ADDR_STACK_LOW   = 8'hD9;
  localparam logic [7:0] RFA_RESET_SLICE_ZERO = 8'hC0;
  localparam logic [7:0] RFA_RESET_SLICE_ONE  = 8'hC8;
  localparam logic [3:0] RFA_WORKING_NIBBLE   = 4'hC;
  localparam logic [1:0] RFA_SET1_TOP         = 2'h3;
  localparam int         RFA_SLICE_LSB        = 3;
  localparam int         RFA_SELECT_BIT       = 3;
  typedef enum logic [3:0] {
    RFA_OP_NONE     = 4'h0,
    RFA_OP_PUSH     = 4'h1,
    RFA_OP_POP      = 4'h2,
    RFA_OP_CALL     = 4'h3,
    RFA_OP_RET      = 4'h4,
    RFA_OP_INT      = 4'h5,
    RFA_OP_INTERRUPT_RETURN     = 4'h6,
    RFA_OP_UPUSH_I  = 4'h7,
    RFA_OP_UPUSH_D  = 4'h8,
    RFA_OP_UPOP_I   = 4'h9,
    RFA_OP_UPOP_D   = 4'hA
  } rfa_op_type;
  typedef enum logic [2:0] {
    RFA_ST_IDLE = 3'b001,
    RFA_ST_MOVE = 3'b010,
    RFA_ST_DONE = 3'b100
  } rfa_state_type;
endpackage

// File: src/rfa_working_decode.sv
// Combinational working-register address former for one operand.
`timescale 1ns/10ps
`default_nettype none
module rfa_working_decode
  import rfa_pkg::*;
(
  input  wire logic [7:0] operand,
  input  wire logic       is_short,
  input  wire logic [7:0] slice_zero,
  input  wire logic [7:0] slice_one,
  output logic      [7:0] address,
  output logic            is_working,
  output logic            is_set2_block
);
  logic [7:0] pointer;
  always_comb begin
    pointer       = operand[RFA_SELECT_BIT] ? slice_one : slice_zero;  // see RULE5
    is_working    = is_short || (operand[7:4] == RFA_WORKING_NIBBLE);  // see RULE7
    // Upper five pointer bits joined with the three low operand bits.
    address       = {pointer[7:RFA_SLICE_LSB], operand[2:0]};          // see RULE6 see RULE15
    is_set2_block = !is_working && (operand[7:6] == RFA_SET1_TOP);     // see RULE1
  end
endmodule
`default_nettype wire

// File: src/rfa_register_addresser.sv
// Register file addressing and stack pointer unit.
// Summary of operation
// RULE1 - Direct register mode reaches everything but set 2, never set 2.
// RULE2 - Word pairs start at even address, high byte even, low byte odd.
// RULE3 - Reset points slice zero to C0H and slice one to C8H.
// RULE4 - Software must reach common area only through working-register addressing.
// RULE5 - Top bit of short operand picks slice pointer zero or one.
// RULE6 - Address is pointer upper five bits joined with operand low three bits.
// RULE7 - Byte operand with upper nibble 1100B is a working-register reference.
// RULE8 - Push decrements before writing; pop reads then increments.
// RULE9 - Stack pointer always addresses the most recently stored entry.
// RULE10 - Call pushes program counter, interrupt pushes counter and flags; returns pop.
// RULE11 - Sixteen-bit stack pointer held as high and low bytes, undefined after reset.
// RULE12 - Low byte carry or borrow propagates into the high byte.
// RULE13 - Software using only the low byte should load FFH, not 00H.
// RULE14 - User stacks anywhere via user push and pop with increment or decrement.
// RULE15 - Low three slice pointer bits are ignored for working addresses.
// RULE16 - Slice pointers sit at D6H and D7H, loadable by load and set-pointers.
`timescale 1ns/10ps
`default_nettype none
module rfa_register_addresser
  import rfa_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
)(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [7:0]       operand,
  input  wire logic             operand_short,
  input  wire logic             operand_pair,
  input  wire logic             reg_write,
  input  wire logic [7:0]       reg_write_addr,
  input  wire logic [7:0]       reg_write_data,
  input  wire logic             set_slice_pointers,
  input  wire logic [1:0]       set_slice_select,
  input  wire logic [7:0]       set_slice_value,
  input  wire rfa_op_type       stack_op,
  input  wire logic [7:0]       user_pointer,
  output logic [ADDR_WIDTH-1:0] operand_addr,
  output logic                  operand_valid,
  output logic                  operand_fault,
  output logic [7:0]            slice_pointer_zero,
  output logic [7:0]            slice_pointer_one,
  output logic [7:0]            stack_pointer_high_byte,
  output logic [7:0]            stack_pointer_low_byte,
  output logic [7:0]            stack_access_addr,
  output logic                  stack_access_write,
  output logic                  stack_access_read,
  output logic [1:0]            stack_access_bytes,
  output logic [7:0]            user_pointer_next,
  output logic                  user_access_valid,
  output logic [7:0]            user_access_addr
);
  logic [7:0]  work_addr;
  logic        work_hit;
  logic        set2_hit;
  logic [7:0]  next_slice_pointer_zero;
  logic [7:0]  next_slice_pointer_one;
  logic [15:0] stack_pointer_word;
  logic [15:0] next_stack_word;
  logic [7:0]  next_operand_addr;
  logic        next_operand_valid;
  logic        next_operand_fault;
  logic [7:0]  next_stack_access_addr;
  logic        next_stack_access_write;
  logic        next_stack_access_read;
  logic [1:0]  next_stack_access_bytes;
  logic [7:0]  next_user_pointer_next;
  logic [7:0]  next_user_access_addr;
  logic        next_user_access_valid;
  logic        stack_write_high;
  logic        stack_write_low;

  function automatic logic [1:0] op_bytes(input rfa_op_type op);
    case (op)
      RFA_OP_PUSH, RFA_OP_POP:  op_bytes = 2'h1;
      RFA_OP_CALL, RFA_OP_RET:  op_bytes = 2'h2;
      RFA_OP_INT,  RFA_OP_INTERRUPT_RETURN: op_bytes = 2'h3;
      default:                  op_bytes = 2'h0;
    endcase
  endfunction

  rfa_working_decode u_decode (
    .operand       (operand),
    .is_short      (operand_short),
    .slice_zero    (slice_pointer_zero),
    .slice_one     (slice_pointer_one),
    .address       (work_addr),
    .is_working    (work_hit),
    .is_set2_block (set2_hit)
  );

  assign stack_pointer_word = {stack_pointer_high_byte, stack_pointer_low_byte};

  // Operand address formation.
  always_comb begin
    next_operand_addr  = work_hit ? work_addr : operand;                  // see RULE1
    next_operand_fault = 1'b0;
    if (operand_pair && next_operand_addr[0]) begin
      next_operand_fault = 1'b1;                                          // see RULE2
    end
    next_operand_valid = !next_operand_fault;
  end

  // Slice pointer loading.
  always_comb begin
    next_slice_pointer_zero = slice_pointer_zero;
    next_slice_pointer_one  = slice_pointer_one;
    if (reg_write && reg_write_addr == RFA_ADDR_SLICE_ZERO) begin
      next_slice_pointer_zero = reg_write_data;                           // see RULE16
    end
    if (reg_write && reg_write_addr == RFA_ADDR_SLICE_ONE) begin
      next_slice_pointer_one = reg_write_data;                            // see RULE16
    end
    if (set_slice_pointers && set_slice_select[0]) begin
      next_slice_pointer_zero = set_slice_value;                          // see RULE16
    end
    if (set_slice_pointers && set_slice_select[1]) begin
      next_slice_pointer_one = set_slice_value;                           // see RULE16
    end
  end

  // Stack pointer arithmetic and stack access addresses.
  always_comb begin
    stack_write_high        = reg_write && reg_write_addr == RFA_ADDR_STACK_HIGH;
    stack_write_low         = reg_write && reg_write_addr == RFA_ADDR_STACK_LOW;
    next_stack_word         = stack_pointer_word;
    next_stack_access_addr  = stack_pointer_low_byte;
    next_stack_access_write = 1'b0;
    next_stack_access_read  = 1'b0;
    next_stack_access_bytes = op_bytes(stack_op);
    next_user_pointer_next  = user_pointer;
    next_user_access_addr   = user_pointer;
    next_user_access_valid  = 1'b0;
    case (stack_op)
      RFA_OP_PUSH, RFA_OP_CALL, RFA_OP_INT: begin
        // Decrement first; the new top is the written entry.
        next_stack_word = stack_pointer_word - {14'h0000, op_bytes(stack_op)};  // see RULE8 see RULE12
        next_stack_access_addr  = next_stack_word[7:0];                   // see RULE9 see RULE10
        next_stack_access_write = 1'b1;
      end
      RFA_OP_POP, RFA_OP_RET, RFA_OP_INTERRUPT_RETURN: begin
        next_stack_word = stack_pointer_word + {14'h0000, op_bytes(stack_op)};  // see RULE8 see RULE12
        next_stack_access_addr = stack_pointer_low_byte;                  // see RULE9 see RULE10
        next_stack_access_read = 1'b1;
      end
      RFA_OP_UPUSH_I: begin
        next_user_pointer_next = user_pointer + 8'h01;                    // see RULE14
        next_user_access_addr  = next_user_pointer_next;
        next_user_access_valid = 1'b1;
      end
      RFA_OP_UPUSH_D: begin
        next_user_pointer_next = user_pointer - 8'h01;                    // see RULE14
        next_user_access_addr  = next_user_pointer_next;
        next_user_access_valid = 1'b1;
      end
      RFA_OP_UPOP_I: begin
        next_user_pointer_next = user_pointer + 8'h01;                    // see RULE14
        next_user_access_valid = 1'b1;
      end
      RFA_OP_UPOP_D: begin
        next_user_pointer_next = user_pointer - 8'h01;                    // see RULE14
        next_user_access_valid = 1'b1;
      end
      default: begin
        next_stack_access_bytes = 2'h0;
      end
    endcase
    if (stack_write_high) begin
      next_stack_word[15:8] = reg_write_data;                             // see RULE11
    end
    if (stack_write_low) begin
      next_stack_word[7:0] = reg_write_data;                              // see RULE11
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slice_pointer_zero <= RFA_RESET_SLICE_ZERO;                         // see RULE3
      slice_pointer_one  <= RFA_RESET_SLICE_ONE;                          // see RULE3
      operand_addr       <= '0;
      operand_valid      <= 1'b0;
      operand_fault      <= 1'b0;
      stack_access_addr  <= 8'h00;
      stack_access_write <= 1'b0;
      stack_access_read  <= 1'b0;
      stack_access_bytes <= 2'h0;
      user_pointer_next  <= 8'h00;
      user_access_addr   <= 8'h00;
      user_access_valid  <= 1'b0;
    end else begin
      slice_pointer_zero <= next_slice_pointer_zero;
      slice_pointer_one  <= next_slice_pointer_one;
      operand_addr       <= ADDR_WIDTH'(next_operand_addr);
      operand_valid      <= next_operand_valid;
      operand_fault      <= next_operand_fault;
      stack_access_addr  <= next_stack_access_addr;
      stack_access_write <= next_stack_access_write;
      stack_access_read  <= next_stack_access_read;
      stack_access_bytes <= next_stack_access_bytes;
      user_pointer_next  <= next_user_pointer_next;
      user_access_addr   <= next_user_access_addr;
      user_access_valid  <= next_user_access_valid;
    end
  end

  // The stack pointer has no reset value.
  always_ff @(posedge clk) begin
    stack_pointer_high_byte <= next_stack_word[15:8];                     // see RULE11
    stack_pointer_low_byte  <= next_stack_word[7:0];
  end

  slice_reset_a: assert property (@(posedge clk) $fell(rst) |->  // see RULE3
    slice_pointer_zero == RFA_RESET_SLICE_ZERO && slice_pointer_one == RFA_RESET_SLICE_ONE)
    else $error("Slice pointers not at common area after reset.");
  push_decrement_a: assert property (@(posedge clk) disable iff (rst)  // see RULE8
    stack_op == RFA_OP_PUSH && !reg_write |=>
    stack_pointer_word == $past(stack_pointer_word) - 16'h0001 && stack_access_write
    && stack_access_addr == stack_pointer_low_byte)
    else $error("Push did not predecrement.");
  pop_increment_a: assert property (@(posedge clk) disable iff (rst)  // see RULE8
    stack_op == RFA_OP_POP && !reg_write |=>
    stack_pointer_word == $past(stack_pointer_word) + 16'h0001
    && stack_access_addr == $past(stack_pointer_low_byte))
    else $error("Pop did not read then increment.");
  carry_high_a: assert property (@(posedge clk) disable iff (rst)  // see RULE12
    stack_op == RFA_OP_POP && !reg_write && stack_pointer_low_byte == 8'hFF |=>
    stack_pointer_high_byte == $past(stack_pointer_high_byte) + 8'h01)
    else $error("Carry missed high byte.");
  short_zero_a: assert property (@(posedge clk) disable iff (rst)  // see RULE5
    operand_short && !operand[3] && !operand_pair |=>
    operand_addr == {$past(slice_pointer_zero[7:3]), $past(operand[2:0])})
    else $error("Short operand address wrong.");
  long_work_a: assert property (@(posedge clk) disable iff (rst)  // see RULE7
    !operand_short && operand[7:4] == RFA_WORKING_NIBBLE && operand[3] && !operand_pair |=>
    operand_addr == {$past(slice_pointer_one[7:3]), $past(operand[2:0])})
    else $error("Working byte operand address wrong.");
  direct_pass_a: assert property (@(posedge clk) disable iff (rst)  // see RULE1
    !operand_short && operand[7:4] != RFA_WORKING_NIBBLE && !operand_pair |=>
    operand_addr == $past(operand))
    else $error("Direct operand altered.");
  set1_direct_a: assert property (@(posedge clk) disable iff (rst)  // see RULE1
    set2_hit && !operand_pair |=> operand_addr == $past(operand) && operand_valid)
    else $error("Direct set 1 operand was redirected.");
  pair_even_a: assert property (@(posedge clk) disable iff (rst)  // see RULE2
    operand_valid |-> !$past(operand_pair) || !operand_addr[0])
    else $error("Odd pair accepted.");
  call_two_a: assert property (@(posedge clk) disable iff (rst)  // see RULE10
    stack_op == RFA_OP_CALL |=> stack_access_bytes == 2'h2 && stack_access_write)
    else $error("Call does not push two bytes.");
  srp_load_a: assert property (@(posedge clk) disable iff (rst)  // see RULE16
    set_slice_pointers && set_slice_select == 2'b01 |=>
    slice_pointer_zero == $past(set_slice_value))
    else $error("Set pointer load failed.");
  push_c: cover property (@(posedge clk) disable iff (rst) stack_op == RFA_OP_PUSH ##1
    stack_op == RFA_OP_POP);
  int_c: cover property (@(posedge clk) disable iff (rst) stack_op == RFA_OP_INT);
  work_c: cover property (@(posedge clk) disable iff (rst) work_hit && !operand_short);
  user_c: cover property (@(posedge clk) disable iff (rst) stack_op == RFA_OP_UPUSH_D);
endmodule
`default_nettype wire

// File: test/rfa_user_stack_model.sv
// Execution datapath model that holds the user stack pointer register beside the addresser.
`timescale 1ns/10ps
`default_nettype none
module rfa_user_stack_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic [7:0] load_value,
  input  wire logic       user_access_valid,
  input  wire logic [7:0] user_pointer_next,
  output logic      [7:0] user_pointer
);
  logic [7:0] next_user_pointer;

  // A load wins; otherwise the pointer follows each user stack access.
  always_comb begin
    next_user_pointer = user_pointer;
    if (load) begin
      next_user_pointer = load_value;
    end else if (user_access_valid) begin
      next_user_pointer = user_pointer_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      user_pointer <= 8'h00;
    end else begin
      user_pointer <= next_user_pointer;
    end
  end
endmodule
`default_nettype wire

// File: test/tb.sv
// Self-checking testbench of the register file addresser and stack pointer unit.
`timescale 1ns/10ps
`default_nettype none
module tb
  import rfa_pkg::*;
;
  logic clk, rst, osh, opr, we, ssp, ld, wr, rd, ov, of, uv;
  logic [7:0] opd, wa, wd, sv, up, ldv, oa, s0, s1, sh, sl, sa, un, ua;
  logic [1:0] ss, sb;
  rfa_op_type sop;
  logic [15:0] sp_exp;
  int bad_count, tests_run;

  rfa_register_addresser i_dut (.clk(clk), .rst(rst), .operand(opd), .operand_short(osh),
    .operand_pair(opr), .reg_write(we), .reg_write_addr(wa), .reg_write_data(wd),
    .set_slice_pointers(ssp), .set_slice_select(ss), .set_slice_value(sv), .stack_op(sop),
    .user_pointer(up), .operand_addr(oa), .operand_valid(ov), .operand_fault(of),
    .slice_pointer_zero(s0), .slice_pointer_one(s1), .stack_pointer_high_byte(sh),
    .stack_pointer_low_byte(sl), .stack_access_addr(sa), .stack_access_write(wr),
    .stack_access_read(rd), .stack_access_bytes(sb), .user_pointer_next(un),
    .user_access_valid(uv), .user_access_addr(ua));

  rfa_user_stack_model i_model (.clk(clk), .rst(rst), .load(ld), .load_value(ldv),
    .user_access_valid(uv), .user_pointer_next(un), .user_pointer(up));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    we <= 1'b1; wa <= a; wd <= d;
    @(posedge clk);
    we <= 1'b0;
    #1;
  endtask

  task automatic slice_set(input logic [1:0] sel, input logic [7:0] v);
    @(posedge clk);
    ssp <= 1'b1; ss <= sel; sv <= v;
    @(posedge clk);
    ssp <= 1'b0;
    #1;
  endtask

  task automatic op_chk(input logic [7:0] o, input logic s, input logic p,
                        input logic [7:0] ea, input logic ev, input logic ef);
    @(posedge clk);
    opd <= o; osh <= s; opr <= p;
    @(posedge clk);
    #1;
    if (ev) check("operand_addr", oa, ea);
    check("operand_valid", ov, ev);
    check("operand_fault", of, ef);
  endtask

  task automatic stk(input rfa_op_type op, input logic [1:0] n, input logic push);
    logic [15:0] old;
    old = sp_exp;
    sp_exp = push ? sp_exp - 16'(n) : sp_exp + 16'(n);
    @(posedge clk);
    sop <= op;
    @(posedge clk);
    sop <= RFA_OP_NONE;
    #1;
    check("stack_pointer", {sh, sl}, sp_exp);
    check("stack_addr", sa, push ? sp_exp[7:0] : old[7:0]);
    check("stack_write", wr, push);
    check("stack_read", rd, !push);
    check("stack_bytes", sb, n);
  endtask

  task automatic usr(input rfa_op_type op, input logic [7:0] ea, input logic [7:0] en);
    @(posedge clk);
    sop <= op;
    @(posedge clk);
    sop <= RFA_OP_NONE;
    #1;
    check("user_valid", uv, 1'b1);
    check("user_addr", ua, ea);
    check("user_next", un, en);
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    end_of_test();
  end

  initial begin
    rst <= 1'b1; opd <= 8'h00; osh <= 1'b0; opr <= 1'b0; we <= 1'b0; wa <= 8'h00;
    wd <= 8'h00; ssp <= 1'b0; ss <= 2'h0; sv <= 8'h00; sop <= RFA_OP_NONE;
    ld <= 1'b0; ldv <= 8'h00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    check("slice_zero_reset", s0, RFA_RESET_SLICE_ZERO);
    check("slice_one_reset", s1, RFA_RESET_SLICE_ONE);
    op_chk(8'h0A, 1'b1, 1'b0, 8'hCA, 1'b1, 1'b0);
    op_chk(8'h03, 1'b1, 1'b0, 8'hC3, 1'b1, 1'b0);
    slice_set(2'b01, 8'h77);
    slice_set(2'b10, 8'hA8);
    check("slice_zero_set", s0, 8'h77);
    check("slice_one_set", s1, 8'hA8);
    op_chk(8'h06, 1'b1, 1'b0, 8'h76, 1'b1, 1'b0);
    op_chk(8'h0E, 1'b1, 1'b0, 8'hAE, 1'b1, 1'b0);
    op_chk(8'hCB, 1'b0, 1'b0, 8'hAB, 1'b1, 1'b0);
    op_chk(8'hC3, 1'b0, 1'b0, 8'h73, 1'b1, 1'b0);
    op_chk(8'h85, 1'b0, 1'b0, 8'h85, 1'b1, 1'b0);
    op_chk(8'hD8, 1'b0, 1'b0, 8'hD8, 1'b1, 1'b0);
    op_chk(8'h41, 1'b0, 1'b1, 8'h00, 1'b0, 1'b1);
    op_chk(8'h40, 1'b0, 1'b1, 8'h40, 1'b1, 1'b0);
    reg_wr(RFA_ADDR_SLICE_ZERO, 8'hC0);
    reg_wr(RFA_ADDR_SLICE_ONE, 8'h3F);
    check("slice_zero_load", s0, 8'hC0);
    check("slice_one_load", s1, 8'h3F);
    op_chk(8'h09, 1'b1, 1'b0, 8'h39, 1'b1, 1'b0);
    reg_wr(RFA_ADDR_STACK_HIGH, 8'h12);
    reg_wr(RFA_ADDR_STACK_LOW, 8'h00);
    sp_exp = 16'h1200;
    check("stack_load", {sh, sl}, sp_exp);
    stk(RFA_OP_PUSH, 2'd1, 1'b1);
    stk(RFA_OP_POP, 2'd1, 1'b0);
    reg_wr(RFA_ADDR_STACK_LOW, 8'hFF);
    sp_exp = 16'h12FF;
    stk(RFA_OP_CALL, 2'd2, 1'b1);
    stk(RFA_OP_INT, 2'd3, 1'b1);
    stk(RFA_OP_PUSH, 2'd1, 1'b1);
    stk(RFA_OP_POP, 2'd1, 1'b0);
    stk(RFA_OP_INTERRUPT_RETURN, 2'd3, 1'b0);
    stk(RFA_OP_RET, 2'd2, 1'b0);
    @(posedge clk);
    ld <= 1'b1; ldv <= 8'h40;
    @(posedge clk);
    ld <= 1'b0;
    usr(RFA_OP_UPUSH_I, 8'h41, 8'h41);
    usr(RFA_OP_UPOP_I, 8'h41, 8'h42);
    usr(RFA_OP_UPUSH_D, 8'h41, 8'h41);
    usr(RFA_OP_UPOP_D, 8'h41, 8'h40);
    check("stack_kept", {sh, sl}, sp_exp);
    end_of_test();
  end
endmodule
`default_nettype wire
